// ===== logic/dcac_top.sv
// dcac_top: one dma channel with its address and count registers and its bus master port
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// Contract
// - start source address register, 32 bits, read/write, resets to 4000_0000.
// - start destination address register, 32 bits, read/write, resets to 4000_0000.
// - byte count is 16 low bits, upper bits reserved, resets to zero.
// - each transaction reads source into a 32-bit buffer, then writes destination.
// - read-only 4-bit pointer tracks the buffer byte in use, resets to zero.
// - read-only register shows the live source address of the running transfer.
// - live source address reloads from start address on trigger and on wrap.
// - 2-bit direction: 00 mem-to-mem, 01 periph-to-mem, 10 mem-to-periph.
// - wrapped mode reloads addresses and count at zero and restarts until disabled.
// - live byte count loads from programmed count on trigger and on wrap.
module dcac_top #(
    parameter int ADDR_W = dcac_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic mem_req_valid_o,
    output dcac_pkg::dcac_mem_req_t mem_req_o,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i
);
    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} dcac_state_t;

    dcac_state_t state, next_state;
    logic ch_on, next_ch_on;
    logic [1:0] dir, next_dir, srcb, next_srcb, dstb, next_dstb, wid, next_wid;
    logic [31:0] src, next_src, dst, next_dst, lsrc, next_lsrc, ldst, next_ldst;
    logic [15:0] cnt, next_cnt, lcnt, next_lcnt;
    logic [3:0] ptr, next_ptr;
    logic [2:0] fill, next_fill;
    logic [31:0] sbuf, next_sbuf;
    logic req_valid, next_req_valid;
    dcac_pkg::dcac_mem_req_t req, next_req;

    logic wr_en, wr_ok, rd_ok, trigger, swrst;
    logic [ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic [2:0] unit, rb, wb, rem;
    logic [31:0] ctrl_view;
    logic wrap_any, end_read;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge
    function automatic logic [2:0] wid_bytes(input logic [1:0] w);
        case (w)
            dcac_pkg::WID_8: return 3'h1;
            dcac_pkg::WID_16: return 3'h2;
            default: return 3'h4;
        endcase
    endfunction : wid_bytes
    function automatic logic [1:0] wid_size(input logic [1:0] w);
        case (w)
            dcac_pkg::WID_8: return dcac_pkg::SIZE_BYTE;
            dcac_pkg::WID_16: return dcac_pkg::SIZE_HALF;
            default: return dcac_pkg::SIZE_WORD;
        endcase
    endfunction : wid_size
    function automatic logic [3:0] lane_mask(input logic [2:0] n);
        return 4'(4'hF >> (3'h4 - n));
    endfunction : lane_mask
    function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] beh,
                                         input logic [2:0] n);
        return (beh == dcac_pkg::AB_FIX) ? a : a + 32'(n);
    endfunction : step
    dcac_axil_slave #(.ADDR_W(ADDR_W)) i_dcac_axil_slave (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o),
        .s_axi_awaddr_i(s_axi_awaddr_i), .s_axi_wvalid_i(s_axi_wvalid_i),
        .s_axi_wready_o(s_axi_wready_o), .s_axi_wdata_i(s_axi_wdata_i),
        .s_axi_wstrb_i(s_axi_wstrb_i), .s_axi_bvalid_o(s_axi_bvalid_o),
        .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
        .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
        .s_axi_araddr_i(s_axi_araddr_i), .s_axi_rvalid_o(s_axi_rvalid_o),
        .s_axi_rready_i(s_axi_rready_i), .s_axi_rdata_o(s_axi_rdata_o),
        .s_axi_rresp_o(s_axi_rresp_o), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .wr_strb_o(wr_strb), .wr_ok_i(wr_ok),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_ok_i(rd_ok)
    );
    assign mem_req_valid_o = req_valid;
    assign mem_req_o = req;
    assign wrap_any = (srcb == dcac_pkg::AB_WRAP) || (dstb == dcac_pkg::AB_WRAP);
    // register view and address decode
    always_comb begin
        ctrl_view = 32'h0000_0000;
        ctrl_view[dcac_pkg::CTL_ON_BIT] = ch_on;
        ctrl_view[dcac_pkg::CTL_DIR_LSB +: 2] = dir;
        ctrl_view[dcac_pkg::CTL_SRCB_LSB +: 2] = srcb;
        ctrl_view[dcac_pkg::CTL_DSTB_LSB +: 2] = dstb;
        ctrl_view[dcac_pkg::CTL_WID_LSB +: 2] = wid;
        ctrl_view[dcac_pkg::CTL_BUSY_BIT] = (state != ST_IDLE);
        rd_ok = 1'b1;
        case ({rd_addr[ADDR_W-1:2], 2'b00})
            ADDR_W'(dcac_pkg::OFS_CTRL): rd_data = ctrl_view;
            ADDR_W'(dcac_pkg::OFS_SRC): rd_data = src;
            ADDR_W'(dcac_pkg::OFS_DST): rd_data = dst;
            ADDR_W'(dcac_pkg::OFS_CNT): rd_data = {16'h0000, cnt};
            ADDR_W'(dcac_pkg::OFS_PTR): rd_data = {28'h000_0000, ptr};
            ADDR_W'(dcac_pkg::OFS_LSRC): rd_data = lsrc;
            default: begin
                rd_data = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
        case ({wr_addr[ADDR_W-1:2], 2'b00})
            ADDR_W'(dcac_pkg::OFS_CTRL), ADDR_W'(dcac_pkg::OFS_SRC),
            ADDR_W'(dcac_pkg::OFS_DST), ADDR_W'(dcac_pkg::OFS_CNT),
            ADDR_W'(dcac_pkg::OFS_PTR), ADDR_W'(dcac_pkg::OFS_LSRC): wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end
    // register writes and the transfer engine share one next-value process
    always_comb begin
        next_state = state;
        next_ch_on = ch_on;
        next_dir = dir;
        next_srcb = srcb;
        next_dstb = dstb;
        next_wid = wid;
        next_src = src;
        next_dst = dst;
        next_cnt = cnt;
        next_lsrc = lsrc;
        next_ldst = ldst;
        next_lcnt = lcnt;
        next_ptr = ptr;
        next_fill = fill;
        next_sbuf = sbuf;
        trigger = 1'b0;
        swrst = 1'b0;
        end_read = 1'b0;
        unit = (dir == dcac_pkg::DIR_P2M || dir == dcac_pkg::DIR_M2P) ? wid_bytes(wid) : 3'h4;
        rb = (dir == dcac_pkg::DIR_P2M) ? unit : 3'h4;
        if (lcnt < 16'(rb)) begin
            rb = lcnt[2:0];
        end
        rem = fill - ptr[2:0];
        wb = (dir != dcac_pkg::DIR_M2P) ? fill : (unit < rem) ? unit : rem;

        if (wr_en) begin
            // pointer and live source offsets decode but never store
            case ({wr_addr[ADDR_W-1:2], 2'b00})
                ADDR_W'(dcac_pkg::OFS_CTRL): begin
                    if (wr_strb[0]) begin
                        next_ch_on = wr_data[dcac_pkg::CTL_ON_BIT];
                        swrst = wr_data[dcac_pkg::CTL_SWRST_BIT];
                        next_dir = wr_data[dcac_pkg::CTL_DIR_LSB +: 2];
                        next_srcb = wr_data[dcac_pkg::CTL_SRCB_LSB +: 2];
                        next_dstb = wr_data[dcac_pkg::CTL_DSTB_LSB +: 2];
                    end
                    if (wr_strb[2]) begin
                        next_wid = wr_data[dcac_pkg::CTL_WID_LSB +: 2];
                        trigger = wr_data[dcac_pkg::CTL_TRIG_BIT];
                    end
                end
                ADDR_W'(dcac_pkg::OFS_SRC): next_src = merge(src, wr_data, wr_strb);
                ADDR_W'(dcac_pkg::OFS_DST): next_dst = merge(dst, wr_data, wr_strb);
                ADDR_W'(dcac_pkg::OFS_CNT): begin
                    next_cnt = 16'(merge({16'h0000, cnt}, wr_data, wr_strb));
                end
                default: ;
            endcase
        end
        case (state)
            ST_IDLE: begin
                if (trigger && next_ch_on && next_cnt != 16'h0000) begin
                    next_lsrc = next_src;
                    next_ldst = next_dst;
                    next_lcnt = next_cnt;
                    next_ptr = 4'h0;
                    next_fill = 3'h0;
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (mem_ack_i) begin
                    next_lsrc = step(lsrc, srcb, rb);
                    next_lcnt = lcnt - 16'(rb);
                    if (dir == dcac_pkg::DIR_P2M) begin
                        for (int i = 0; i < 4; i++) begin
                            if (i >= int'(ptr) && i < int'(ptr) + int'(rb)) begin
                                next_sbuf[i*8 +: 8] = mem_rdata_i[(i - int'(ptr))*8 +: 8];
                            end
                        end
                        next_ptr = ptr + 4'(rb);
                        next_fill = fill + rb;
                        if (next_ptr == 4'h4 || next_lcnt == 16'h0000) begin
                            next_state = ST_WRITE;
                        end
                    end else begin
                        next_sbuf = mem_rdata_i;
                        next_ptr = 4'h0;
                        next_fill = rb;
                        next_state = ST_WRITE;
                    end
                    // a disabled channel drops what sits in the buffer
                    if (!ch_on) begin
                        next_state = ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (mem_ack_i) begin
                    next_ldst = step(ldst, dstb, wb);
                    if (dir == dcac_pkg::DIR_M2P && ptr[2:0] + wb < fill) begin
                        next_ptr = ptr + 4'(wb);
                    end else begin
                        end_read = 1'b1;
                        next_ptr = 4'h0;
                        next_fill = 3'h0;
                    end
                end
                if (end_read) begin
                    if (!ch_on) begin
                        next_state = ST_IDLE;
                    end else if (lcnt != 16'h0000) begin
                        next_state = ST_READ;
                    end else if (wrap_any) begin
                        next_lsrc = src;
                        next_ldst = dst;
                        next_lcnt = cnt;
                        next_state = (cnt != 16'h0000) ? ST_READ : ST_IDLE;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // engine reset clears the enable bit and keeps the other programmed values
        if (swrst) begin
            next_ch_on = 1'b0;
            next_state = ST_IDLE;
            next_ptr = 4'h0;
            next_fill = 3'h0;
        end
    end

    // bus master request is built from next values so it leaves a flip-flop
    always_comb begin
        next_req = '0;
        next_req_valid = (next_state != ST_IDLE);
        if (next_state == ST_READ) begin
            next_req.addr = next_lsrc;
            next_req.size = (next_dir == dcac_pkg::DIR_P2M) ? wid_size(next_wid)
                                                             : dcac_pkg::SIZE_WORD;
        end else if (next_state == ST_WRITE) begin
            next_req.we = 1'b1;
            next_req.addr = next_ldst;
            if (next_dir == dcac_pkg::DIR_M2P) begin
                next_req.size = wid_size(next_wid);
                next_req.wdata = next_sbuf >> {next_ptr, 3'b000};
                next_req.strb = lane_mask(wid_bytes(next_wid));
            end else begin
                next_req.size = dcac_pkg::SIZE_WORD;
                next_req.wdata = next_sbuf;
                next_req.strb = lane_mask(next_fill);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            ch_on <= 1'b0;
            dir <= dcac_pkg::DIR_M2M;
            srcb <= dcac_pkg::AB_INC;
            dstb <= dcac_pkg::AB_INC;
            wid <= dcac_pkg::WID_32;
            src <= dcac_pkg::RST_ADDR;
            dst <= dcac_pkg::RST_ADDR;
            cnt <= dcac_pkg::RST_CNT;
            lsrc <= dcac_pkg::RST_LSRC;
            ldst <= dcac_pkg::RST_LSRC;
            lcnt <= dcac_pkg::RST_CNT;
            ptr <= dcac_pkg::RST_PTR;
            fill <= 3'h0;
            sbuf <= 32'h0000_0000;
            req_valid <= 1'b0;
            req <= '0;
        end else begin
            state <= next_state;
            ch_on <= next_ch_on;
            dir <= next_dir;
            srcb <= next_srcb;
            dstb <= next_dstb;
            wid <= next_wid;
            src <= next_src;
            dst <= next_dst;
            cnt <= next_cnt;
            lsrc <= next_lsrc;
            ldst <= next_ldst;
            lcnt <= next_lcnt;
            ptr <= next_ptr;
            fill <= next_fill;
            sbuf <= next_sbuf;
            req_valid <= next_req_valid;
            req <= next_req;
        end
    end
endmodule : dcac_top

// ===== logic/dcac_pkg.sv
// dcac_pkg: register map, field layout, reset values and bus types of the dma channel
package dcac_pkg;
    localparam int ADDR_W = 8;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SRC = 8'h04;
    localparam logic [7:0] OFS_DST = 8'h08;
    localparam logic [7:0] OFS_CNT = 8'h0C;
    localparam logic [7:0] OFS_PTR = 8'h10;
    localparam logic [7:0] OFS_LSRC = 8'h14;

    localparam logic [31:0] RST_ADDR = 32'h4000_0000;
    localparam logic [15:0] RST_CNT = 16'h0000;
    localparam logic [31:0] RST_LSRC = 32'h0FFF_FFFF;
    localparam logic [3:0] RST_PTR = 4'h0;

    localparam int CTL_ON_BIT = 0;
    localparam int CTL_SWRST_BIT = 1;
    localparam int CTL_DIR_LSB = 2;
    localparam int CTL_SRCB_LSB = 4;
    localparam int CTL_DSTB_LSB = 6;
    localparam int CTL_WID_LSB = 19;
    localparam int CTL_TRIG_BIT = 23;
    localparam int CTL_BUSY_BIT = 31;

    localparam logic [1:0] DIR_M2M = 2'h0;
    localparam logic [1:0] DIR_P2M = 2'h1;
    localparam logic [1:0] DIR_M2P = 2'h2;

    localparam logic [1:0] AB_INC = 2'h0;
    localparam logic [1:0] AB_FIX = 2'h2;
    localparam logic [1:0] AB_WRAP = 2'h3;

    localparam logic [1:0] WID_32 = 2'h0;
    localparam logic [1:0] WID_8 = 2'h1;
    localparam logic [1:0] WID_16 = 2'h2;

    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic we;
        logic [31:0] addr;
        logic [1:0] size;
        logic [3:0] strb;
        logic [31:0] wdata;
    } dcac_mem_req_t;
endpackage : dcac_pkg

// ===== logic/dcac_axil_slave.sv
// dcac_axil_slave: axi4-lite register port turning bus traffic into write pulses and read lookups
`timescale 1ns/1ps
module dcac_axil_slave #(
    parameter int ADDR_W = dcac_pkg::ADDR_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic wr_en_o,
    output logic [ADDR_W-1:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_ok_i,
    output logic [ADDR_W-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_ok_i
);
    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [31:0] rdata, next_rdata;
    logic [1:0] rresp, next_rresp;

    if (ADDR_W < 5) begin : g_bad_width
        $error("dcac_axil_slave: ADDR_W too small for the register map");
    end

    // address and data are latched apart, so either may come first
    assign s_axi_awready_o = !aw_held && !bvalid;
    assign s_axi_wready_o = !w_held && !bvalid;
    assign s_axi_arready_o = !rvalid;
    assign s_axi_bvalid_o = bvalid;
    assign s_axi_bresp_o = bresp;
    assign s_axi_rvalid_o = rvalid;
    assign s_axi_rdata_o = rdata;
    assign s_axi_rresp_o = rresp;
    assign wr_en_o = aw_held && w_held && !bvalid;
    assign wr_addr_o = aw_addr;
    assign wr_data_o = w_data;
    assign wr_strb_o = w_strb;
    assign rd_addr_o = s_axi_araddr_i;

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (s_axi_awvalid_i && s_axi_awready_o) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata_i;
            next_w_strb = s_axi_wstrb_i;
        end
        if (wr_en_o) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_ok_i ? dcac_pkg::RESP_OKAY : dcac_pkg::RESP_SLVERR;
        end else if (bvalid && s_axi_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o) begin
            next_rvalid = 1'b1;
            next_rdata = rd_ok_i ? rd_data_i : 32'h0000_0000;
            next_rresp = rd_ok_i ? dcac_pkg::RESP_OKAY : dcac_pkg::RESP_SLVERR;
        end else if (rvalid && s_axi_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end
endmodule : dcac_axil_slave

// ===== verification/dcac_checker.sv
// dcac_checker: port assertions of the dma channel
`timescale 1ns/1ps
module dcac_checker (
    input wire logic clk_i, input wire logic rstn_i,
    input wire logic s_axi_awready_o, input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o, input wire logic s_axi_bready_i,
    input wire logic s_axi_arvalid_i, input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o, input wire logic s_axi_rready_i,
    input wire logic mem_ack_i, input wire logic mem_req_valid_o,
    input wire dcac_pkg::dcac_mem_req_t mem_req_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_req_hold: assert property (mem_req_valid_o && !mem_ack_i
        |=> mem_req_valid_o && $stable(mem_req_o)) else $error("request moved");
    a_read_first: assert property ($rose(mem_req_valid_o) |-> !mem_req_o.we)
        else $error("transfer began with a write");
    a_word_align: assert property (mem_req_valid_o && mem_req_o.size == 2'h2
        |-> mem_req_o.addr[1:0] == 2'h0) else $error("word misaligned");
    a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
        else $error("no read answer");
    a_r_stand: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
        else $error("rvalid dropped early");
    a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
        else $error("rvalid stuck");
    a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
        else $error("bvalid stuck");
    a_w_block: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("ready while answering");
    c_mem_wr: cover property (mem_req_valid_o && mem_ack_i && mem_req_o.we);
    c_mem_rd: cover property (mem_req_valid_o && mem_ack_i && !mem_req_o.we);
    c_wr_done: cover property (s_axi_bvalid_o && s_axi_bready_i);
endmodule : dcac_checker

// ===== verification/dcac_mem_model.sv
// dcac_mem_model: bus memory that answers the channel's requests
`timescale 1ns/1ps
module dcac_mem_model (
    input wire logic clk_i, input wire logic rstn_i, input wire logic [3:0] wait_i,
    input wire logic req_valid_i, input wire dcac_pkg::dcac_mem_req_t req_i,
    output logic ack_o, output logic [31:0] rdata_o,
    output dcac_pkg::dcac_mem_req_t last_wr_o, output logic [7:0] n_wr_o
);
    logic [3:0] cnt;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {ack_o, rdata_o, last_wr_o, n_wr_o, cnt} <= '0;
        end else if (req_valid_i && !ack_o && cnt >= wait_i) begin
            ack_o <= 1'b1;
            rdata_o <= req_i.addr ^ 32'hC3C3_0000;
            cnt <= 4'h0;
            if (req_i.we) last_wr_o <= req_i;
            n_wr_o <= n_wr_o + {7'h0, req_i.we};
        end else begin
            ack_o <= 1'b0;
            // read data means nothing without ack, so keep it moving
            rdata_o <= ~rdata_o;
            cnt <= (req_valid_i && !ack_o) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule : dcac_mem_model

// ===== verification/tb_dma_channel_address_count.sv
// tb_dma_channel_address_count: register and transfer tests
`timescale 1ns/1ps
module tb_dma_channel_address_count;
    logic clk_i = 1'b0, rstn_i = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0;
    logic rready = 1'b0, awr, wrd, bv, arr, rv, ack, mvalid;
    logic [7:0] a8 = 8'h00, n_wr, base;
    logic [31:0] wd = 32'h0, rdd, mrd, v;
    logic [3:0] ws = 4'hF, mwait = 4'h0;
    logic [1:0] bresp, rresp, r;
    dcac_pkg::dcac_mem_req_t req, lw;
    int fail_count = 0, n_checks = 0;
    dcac_top i_dcac_top (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awvalid_i(awv),
        .s_axi_awready_o(awr), .s_axi_awaddr_i(a8), .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv),
        .s_axi_wready_o(wrd), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bready), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(a8), .s_axi_arprot_i(3'h0), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rready), .s_axi_rdata_o(rdd), .s_axi_rresp_o(rresp),
        .mem_req_valid_o(mvalid), .mem_req_o(req), .mem_ack_i(ack), .mem_rdata_i(mrd));
    dcac_mem_model i_dcac_mem_model (.clk_i(clk_i), .rstn_i(rstn_i), .wait_i(mwait),
        .req_valid_i(mvalid), .req_i(req), .ack_o(ack), .rdata_o(mrd), .last_wr_o(lw),
        .n_wr_o(n_wr));
    initial forever #2.5 clk_i = ~clk_i;
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    // one axi4-lite write (w=1) or read (w=0); answer lands in r and v
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {awv, wv, bready} <= {3{w}};
        {arv, rready} <= {2{!w}};
        a8 <= a;
        wd <= d;
        do begin
            @(posedge clk_i);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (arr) arv <= 1'b0;
        end while (bv !== 1'b1 && rv !== 1'b1);
        {r, v} = w ? {bresp, 32'h0} : {rresp, rdd};
        {bready, rready} <= 2'b00;
    endtask : acc
    task automatic rk(input string s, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(s, v, e);
    endtask : rk
    task automatic idle();
        do acc(1'b0, 8'h00, 32'h0); while (v[31] !== 1'b0);
    endtask : idle
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        rk("src", 8'h04, 32'h4000_0000);
        rk("dst", 8'h08, 32'h4000_0000);
        rk("cnt", 8'h0C, 32'h0000_0000);
        rk("ptr", 8'h10, 32'h0000_0000);
        rk("lsrc", 8'h14, 32'h0FFF_FFFF);
        acc(1'b1, 8'h0C, 32'hFFFF_FFFF);
        rk("cnt_max", 8'h0C, 32'h0000_FFFF);
        acc(1'b1, 8'h10, 32'h0000_000F);
        acc(1'b1, 8'h14, 32'h1234_5678);
        chk("ro_bresp", {30'h0, r}, {30'h0, dcac_pkg::RESP_OKAY});
        rk("ptr_ro", 8'h10, 32'h0000_0000);
        rk("lsrc_ro", 8'h14, 32'h0FFF_FFFF);
        acc(1'b0, 8'h40, 32'h0);
        chk("unmapped", {r, v[29:0]}, {dcac_pkg::RESP_SLVERR, 30'h0});
        ws <= 4'h1;
        acc(1'b1, 8'h08, 32'h0000_0040);
        ws <= 4'hF;
        acc(1'b1, 8'h04, 32'h2000_0010);
        rk("dst_lane", 8'h08, 32'h4000_0040);
        rk("src_rw", 8'h04, 32'h2000_0010);
        acc(1'b1, 8'h0C, 32'h0000_0008);
        acc(1'b1, 8'h00, 32'h0080_0001);
        idle();
        chk("m2m_addr", lw.addr, 32'h4000_0044);
        chk("m2m_data", lw.wdata, 32'hE3C3_0014);
        mwait <= 4'h3;
        acc(1'b1, 8'h0C, 32'h0000_0004);
        base = n_wr;
        acc(1'b1, 8'h00, 32'h0088_0089);
        idle();
        chk("m2p_n", {24'h0, n_wr - base}, 32'h4);
        chk("m2p_last", {lw.addr[15:0], lw.wdata[7:0], 2'h0, lw.size, lw.strb},
            {16'h0040, 8'hE3, 2'h0, 2'h0, 4'h1});
        rk("m2p_lsrc", 8'h14, 32'h2000_0014);
        acc(1'b1, 8'h0C, 32'h0000_0008);
        acc(1'b1, 8'h00, 32'h0090_0025);
        idle();
        chk("p2m_data", lw.wdata, 32'h0010_0010);
        chk("p2m_addr", lw.addr, 32'h4000_0044);
        rk("p2m_lsrc", 8'h14, 32'h2000_0010);
        mwait <= 4'h0;
        acc(1'b1, 8'h0C, 32'h0000_0004);
        base = n_wr;
        acc(1'b1, 8'h00, 32'h0080_0031);
        wait (n_wr - base >= 8'h03);
        acc(1'b1, 8'h00, 32'h0000_0000);
        idle();
        chk("wrap_addr", lw.addr, 32'h4000_0040);
        chk("wrap_data", lw.wdata, 32'hE3C3_0010);
        give_verdict();
    end
endmodule : tb_dma_channel_address_count
bind dcac_top dcac_checker i_dcac_checker (.clk_i, .rstn_i, .s_axi_awready_o, .s_axi_wready_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .mem_ack_i, .mem_req_valid_o, .mem_req_o);
